/* tap_attr_pipe.sv */
// The address map and strobed register access were chosen for this implementation.
`default_nettype none
`include "tap_regs.svh"
module tap_attr_pipe
  import tap_pkg::*;
#(
  parameter int CNT_W  = 16,
  parameter bit S2_XNX = 1'b1
) (
  input  wire logic        clk_i,        // 50 MHz clock
  input  wire logic        nrst_i,       // Async reset, active low
  input  wire logic [7:0]  addr_i,       // Register address
  input  wire logic [31:0] wdata_i,      // Register write data
  input  wire logic        we_i,         // Write strobe
  input  wire logic        re_i,         // Read strobe
  output logic      [31:0] rdata_o,      // Read data, cycle after strobe
  input  wire logic        in_vld_i,     // Transaction valid
  input  wire tap_txn_t    txn_i,        // Client attributes
  input  wire tap_ste_t    ste_i,        // Stream configuration
  input  wire tap_s1_t     s1_i,         // Stage 1 walk result
  input  wire tap_s2_t     s2_i,         // Stage 2 walk result
  output logic             out_vld_o,    // Output valid
  output tap_attrs_t       out_o,        // Final attributes
  output logic             abort_o,      // Transaction aborted
  output logic             event_o,      // Fault event to record
  output logic             fault_s2_o,   // Fault came from stage 2
  output logic             upd_af_o,     // Set access flag
  output logic             upd_dirty_o,  // Mark page dirty
  output logic             s2_walk_ns_o  // Stage 2 walk space
);

  logic [`TAP_CTRL_RW_W-1:0] ctrl_q;
  tap_ovr_t                  global_bypass_attrs_ns_q, global_bypass_attrs_s_q;
  tap_attrs_t                stat_q;
  logic [CNT_W-1:0]          aborts_q;
  logic [31:0]               rdata_q;

  tap_attrs_t out_q, ia, i_d;
  tap_ovr_t   ov;
  tap_mem_t   s1m, hsv;
  logic out_vld_q, abort_q, event_q, fs2_q, uaf_q, udty_q, wns_q;
  logic byp, abort_d, event_d, fs2_d, uaf_d, udty_d, wns_d;
  logic hi, pe, ap1, dn1, dn2, xd2, sipa_ns, nsipa_ns, spec_rd, httu;

  function automatic logic [1:0] cmin(input logic [1:0] a, input logic [1:0] b);
    return (a < b) ? a : b;
  endfunction : cmin

  function automatic logic [1:0] sh_rank(input logic [1:0] s);
    return (s == `TAP_SH_OSH) ? 2'h2 : (s == `TAP_SH_ISH) ? 2'h1 : 2'h0;
  endfunction : sh_rank

  // Stronger of two memory types, level by level
  function automatic tap_mem_t combine(input tap_mem_t a, input tap_mem_t b);
    tap_mem_t r;
    r = a;
    r.ic = cmin(a.ic, b.ic);
    r.oc = cmin(a.oc, b.oc);
    r.ra = a.ra & b.ra;
    r.wa = a.wa & b.wa;
    r.tr = a.tr | b.tr;
    r.sh = (sh_rank(b.sh) > sh_rank(a.sh)) ? b.sh : a.sh;
    r.dev = a.dev | b.dev;
    r.dtype = cmin(a.dev ? a.dtype : `TAP_DEV_NONE, b.dev ? b.dtype : `TAP_DEV_NONE);
    return r;
  endfunction : combine

  function automatic tap_mem_t dev_of(input logic [1:0] dt, input logic [1:0] sh);
    tap_mem_t r;
    r = '0;
    r.dev = 1'b1;
    r.dtype = dt;
    r.sh = sh;
    return r;
  endfunction : dev_of

  // One nibble of an attr_index_table entry
  function automatic logic [4:0] attr_index_table_half(input logic [3:0] h);
    logic [1:0] c;
    c = h[2] ? `TAP_CACHE_WB : `TAP_CACHE_WT;
    if (h == 4'h4 || h == 4'h0) return {`TAP_CACHE_NC, 3'h0};
    return {c, h[1], h[0], ~h[3]};
  endfunction : attr_index_table_half

  function automatic tap_mem_t attr_index_table_lookup(input logic [63:0] t, input logic [2:0] ix,
                                           input logic [1:0] sh);
    logic [7:0] b;
    logic [4:0] o, n;
    tap_mem_t   r;
    b = t[ix*`TAP_ATTR_INDEX_TABLE_EW +: `TAP_ATTR_INDEX_TABLE_EW];
    o = attr_index_table_half(b[7:4]);
    n = attr_index_table_half(b[3:0]);
    r = '0;
    if (b[7:4] == 4'h0) return dev_of(b[3:2], sh);
    r.oc = o[4:3];
    r.ic = n[4:3];
    r.ra = {o[2], n[2]};
    r.wa = {o[1], n[1]};
    r.tr = {o[0], n[0]};
    r.sh = sh;
    return r;
  endfunction : attr_index_table_lookup

  function automatic logic [1:0] s2c(input logic [1:0] x);
    return (x == 2'h3) ? `TAP_CACHE_WB : (x == 2'h2) ? `TAP_CACHE_WT : `TAP_CACHE_NC;
  endfunction : s2c

  // Stage 2 combine, plain or forced write-back encoding
  function automatic tap_mem_t s2_comb(input tap_mem_t a, input tap_s2_t s, input logic fwb);
    tap_mem_t d, r;
    logic [3:0] ma;
    ma = s.s2_memory_attr_field;
    d = a;
    d.sh = s.sh;
    d.ra = 2'h3;
    d.wa = 2'h3;
    d.tr = 2'h0;
    d.dev = 1'b0;
    if (!fwb) begin
      d.oc = s2c(ma[3:2]);
      d.ic = s2c(ma[1:0]);
      r = combine(a, (ma[3:2] == 2'h0) ? dev_of(ma[1:0], s.sh) : d);
    end else if (!ma[2]) begin
      r = combine(a, dev_of(ma[1:0], s.sh));
    end else if (ma[1:0] == 2'h3) begin
      r = combine(a, d);
      r.dev = 1'b0;
      r.ic = `TAP_CACHE_WB;
      r.oc = `TAP_CACHE_WB;
    end else if (ma[1:0] == 2'h2) begin
      r = combine(a, d);
    end else begin
      d.ic = `TAP_CACHE_NC;
      d.oc = `TAP_CACHE_NC;
      r = combine(a, d);
    end
    return r;
  endfunction : s2_comb

  function automatic logic cfg_sel(input logic [1:0] c, input logic v);
    return c[`TAP_CFG_SET] ? c[0] : v;
  endfunction : cfg_sel

  // Override fields replace chosen attributes
  function automatic tap_attrs_t replace(input tap_ovr_t o, input tap_attrs_t a);
    tap_attrs_t r;
    r = a;
    if (o.mt_en) begin
      r.m.dev = o.mt_dev;
      r.m.dtype = o.mt_dt;
      r.m.ic = o.mt_ic;
      r.m.oc = o.mt_oc;
    end
    if (o.sh_en) r.m.sh = o.sh;
    if (o.al_en) begin
      r.m.ra = {2{o.ra}};
      r.m.wa = {2{o.wa}};
      r.m.tr = {2{o.tr}};
    end
    r.privilege_attr = cfg_sel(o.privilege_attr_cfg, a.privilege_attr);
    r.inst = cfg_sel(o.inst_cfg, a.inst);
    r.ns = cfg_sel(o.ns_cfg, a.ns);
    return r;
  endfunction : replace

  // Outer shareable for uncached, no hints on uncached levels
  function automatic tap_mem_t consistent(input tap_mem_t m);
    tap_mem_t r;
    r = m;
    if (m.dev) begin
      r.ic = `TAP_CACHE_NC;
      r.oc = `TAP_CACHE_NC;
    end
    if (r.ic == `TAP_CACHE_NC) begin
      r.ra[0] = 1'b0;
      r.wa[0] = 1'b0;
      r.tr[0] = 1'b0;
    end
    if (r.oc == `TAP_CACHE_NC) begin
      r.ra[1] = 1'b0;
      r.wa[1] = 1'b0;
      r.tr[1] = 1'b0;
    end
    r.tr = r.tr & (r.ra | r.wa);
    if (m.dev || (r.ic == `TAP_CACHE_NC && r.oc == `TAP_CACHE_NC)) r.sh = `TAP_SH_OSH;
    return r;
  endfunction : consistent

  assign httu = ctrl_q[`TAP_CTRL_HTTU];

  // Default filling for unsupplied attributes
  always_comb begin
    ia = txn_i.a;
    if (!txn_i.sup.mt) {ia.m.dev, ia.m.dtype, ia.m.ic, ia.m.oc} = 7'(`TAP_DEF_MEM >> 8);
    if (!txn_i.sup.al) {ia.m.ra, ia.m.wa, ia.m.tr} = 6'((`TAP_DEF_MEM >> 2) & 15'h3f);
    if (!txn_i.sup.sh) ia.m.sh = 2'(`TAP_DEF_MEM & 15'h3);
    if (!txn_i.sup.inst) ia.inst = `TAP_DEF_INST;
    if (!txn_i.sup.privilege_attr) ia.privilege_attr = `TAP_DEF_PRIVILEGE_ATTR;
    if (!txn_i.sup.ns) ia.ns = `TAP_DEF_NS;
  end

  always_comb begin
    byp = txn_i.secure ? !ctrl_q[`TAP_CTRL_EN_S] : !ctrl_q[`TAP_CTRL_EN_NS];
    ov = byp ? (txn_i.secure ? global_bypass_attrs_s_q : global_bypass_attrs_ns_q) : ste_i.ovr;
    i_d = replace(ov, ia);
    spec_rd = txn_i.spec && !i_d.rw;
    abort_d = 1'b0;
    event_d = 1'b0;
    fs2_d = 1'b0;
    uaf_d = 1'b0;
    udty_d = 1'b0;
    wns_d = 1'b0;
    hi = (s1_i.regime == TAP_EL2) || (s1_i.regime == TAP_EL3);
    pe = hi || i_d.privilege_attr;
    ap1 = hi || s1_i.ap[0];
    dn1 = (!pe && !ap1) || (i_d.inst && (pe ? s1_i.pxn : s1_i.uxn)) ||
          (i_d.rw && s1_i.ap[1] && !(httu && s1_i.dbm)) || (!s1_i.af && !httu);
    s1m = attr_index_table_lookup(s1_i.attr_index_table, s1_i.attr_index_field, s1_i.sh);
    if (!byp && ste_i.s1_en) begin
      if (s1_i.fault) begin
        abort_d = 1'b1;
        event_d = !spec_rd;
      end else if (dn1) begin
        abort_d = 1'b1;
        event_d = 1'b1;
      end else begin
        uaf_d = !s1_i.af;
        udty_d = i_d.rw && s1_i.ap[1];
      end
      if (!i_d.m.dev && (i_d.m.ic != `TAP_CACHE_NC || i_d.m.oc != `TAP_CACHE_NC)) begin
        s1m.ra = s1m.ra & i_d.m.ra;
        s1m.wa = s1m.wa & i_d.m.wa;
        s1m.tr = s1m.tr | i_d.m.tr;
      end
      i_d.m = s1m;
      i_d.ns = s1_i.ns || s1_i.tbl_ns || s1_i.walk_nonsecure_cfg[s1_i.ttb];
    end
    xd2 = S2_XNX ? ((s2_i.xn == 2'h2) || (i_d.privilege_attr ? s2_i.xn == 2'h1 : s2_i.xn == 2'h3))
                 : s2_i.xn[1];
    dn2 = (!i_d.rw && !s2_i.s2ap[0]) || (i_d.rw && !s2_i.s2ap[1] && !(httu && s2_i.dbm)) ||
          (i_d.inst && xd2) || (!s2_i.af && !httu);
    sipa_ns = ste_i.s2_sipa_walk_cfg || ste_i.s2_sipa_output_cfg;
    nsipa_ns = ste_i.s2_nsipa_walk_cfg || sipa_ns || ste_i.s2_nsipa_output_cfg;
    hsv = i_d.m;
    if (!byp && ste_i.s2_en && !abort_d) begin
      i_d.m = s2_comb(i_d.m, s2_i, ste_i.fwb);
      i_d.m.ra = hsv.ra;
      i_d.m.wa = hsv.wa;
      i_d.m.tr = hsv.tr;
      if (s2_i.fault || dn2) begin
        abort_d = 1'b1;
        event_d = !(s2_i.fault && spec_rd);
        fs2_d = 1'b1;
      end else begin
        uaf_d = uaf_d || !s2_i.af;
        udty_d = udty_d || (i_d.rw && !s2_i.s2ap[1]);
      end
      if (txn_i.secure && ste_i.s2_sec_en) begin
        wns_d = i_d.ns ? ste_i.s2_nsipa_walk_cfg : ste_i.s2_sipa_walk_cfg;
        i_d.ns = i_d.ns ? nsipa_ns : sipa_ns;
      end else begin
        wns_d = !txn_i.secure || i_d.ns;
      end
    end
    if (!txn_i.secure) i_d.ns = 1'b1;
    i_d.m = consistent(i_d.m);
  end

  // Output stage
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_vld_q <= 1'b0;
      out_q <= '0;
      abort_q <= 1'b0;
      event_q <= 1'b0;
      fs2_q <= 1'b0;
      uaf_q <= 1'b0;
      udty_q <= 1'b0;
      wns_q <= 1'b0;
    end else begin
      out_vld_q <= in_vld_i;
      abort_q <= in_vld_i && abort_d;
      event_q <= in_vld_i && event_d;
      fs2_q <= in_vld_i && fs2_d;
      uaf_q <= in_vld_i && uaf_d;
      udty_q <= in_vld_i && udty_d;
      if (in_vld_i) begin
        out_q <= i_d;
        wns_q <= wns_d;
      end
    end
  end

  // Register writes
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= `TAP_CTRL_RST;
      global_bypass_attrs_ns_q <= `TAP_GLOBAL_BYPASS_ATTRS_RST;
      global_bypass_attrs_s_q <= `TAP_GLOBAL_BYPASS_ATTRS_RST;
    end else if (we_i) begin
      case (addr_i)
        `TAP_OFF_CTRL:    ctrl_q <= wdata_i[`TAP_CTRL_RW_W-1:0];
        `TAP_OFF_GLOBAL_BYPASS_ATTRS_NS: global_bypass_attrs_ns_q <= wdata_i[`TAP_GLOBAL_BYPASS_ATTRS_W-1:0];
        `TAP_OFF_GLOBAL_BYPASS_ATTRS_S:  global_bypass_attrs_s_q <= wdata_i[`TAP_GLOBAL_BYPASS_ATTRS_W-1:0];
        default: ;
      endcase
    end
  end

  // Last output and abort count
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_q <= '0;
      aborts_q <= '0;
    end else begin
      if (out_vld_q) stat_q <= out_q;
      if (abort_q) aborts_q <= aborts_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= '0;
    end else if (re_i) begin
      case (addr_i)
        `TAP_OFF_CTRL:    rdata_q <= {28'h0, S2_XNX, ctrl_q};
        `TAP_OFF_GLOBAL_BYPASS_ATTRS_NS: rdata_q <= {11'h0, global_bypass_attrs_ns_q};
        `TAP_OFF_GLOBAL_BYPASS_ATTRS_S:  rdata_q <= {11'h0, global_bypass_attrs_s_q};
        `TAP_OFF_STATUS:  rdata_q <= {13'h0, stat_q};
        `TAP_OFF_ABORTS:  rdata_q <= 32'(aborts_q);
        default:          rdata_q <= 32'h0;
      endcase
    end else begin
      rdata_q <= 32'h0;
    end
  end

  assign rdata_o = rdata_q;
  assign out_vld_o = out_vld_q;
  assign out_o = out_q;
  assign abort_o = abort_q;
  assign event_o = event_q;
  assign fault_s2_o = fs2_q;
  assign upd_af_o = uaf_q;
  assign upd_dirty_o = udty_q;
  assign s2_walk_ns_o = wns_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  chk_ns_forced: assert property (in_vld_i && !txn_i.secure |=> out_q.ns)
    else $error("nonsecure stream output ns 0");
  chk_dev_osh: assert property (out_vld_q && out_q.m.dev |-> out_q.m.sh == `TAP_SH_OSH)
    else $error("device output not outer shareable");
  chk_nc_nohint: assert property (out_vld_q && out_q.m.ic == `TAP_CACHE_NC
                                  |-> out_q.m.ra[0] == 1'b0 && out_q.m.tr[0] == 1'b0)
    else $error("hint on uncached inner level");
  chk_spec_silent: assert property (in_vld_i && !byp && ste_i.s1_en && s1_i.fault
                                    && spec_rd |=> abort_q && !event_q)
    else $error("speculative read fault recorded");
  chk_httu_af: assert property (in_vld_i && !byp && ste_i.s1_en && !s1_i.fault && !dn1
                                && !s1_i.af |=> uaf_q && (fs2_q || !abort_q))
    else $error("access flag not updated");
  chk_s2_sipa: assert property (in_vld_i && !byp && ste_i.s2_en && txn_i.secure
                                && ste_i.s2_sec_en && ste_i.s2_sipa_walk_cfg && !abort_d |=> out_q.ns)
    else $error("secure stage 2 space wrong");
  chk_walk_cfg: assert property (in_vld_i && !byp && ste_i.s1_en && !ste_i.s2_en
                                 && s1_i.walk_nonsecure_cfg[s1_i.ttb] |=> out_q.ns)
    else $error("walk nonsecure config ignored");
  chk_privilege_attr_pass: assert property (in_vld_i && !byp && ste_i.ovr.privilege_attr_cfg[`TAP_CFG_SET]
                                  |=> out_q.privilege_attr == $past(ste_i.ovr.privilege_attr_cfg[0]))
    else $error("privilege override not kept");
  chk_bypass_mt: assert property (in_vld_i && byp && !txn_i.secure && global_bypass_attrs_ns_q.mt_en
                                  |=> out_q.m.dev == $past(global_bypass_attrs_ns_q.mt_dev) && out_q.ns)
    else $error("global bypass type not applied");
  chk_el2_privilege_attr: assert property (in_vld_i && hi && s1_i.ap == 2'h0 && s1_i.af
                                 && !i_d.inst |-> !dn1)
    else $error("low ap bit not treated as one");
  chk_abort_cnt: assert property (abort_q && aborts_q != '1
                                  |=> aborts_q == $past(aborts_q) + 1)
    else $error("abort count not advanced");

endmodule : tap_attr_pipe
`default_nettype wire

/* tap_regs.svh */
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH
// Register offsets on the plain register port
`define TAP_OFF_CTRL    8'h00
`define TAP_OFF_GLOBAL_BYPASS_ATTRS_NS 8'h04
`define TAP_OFF_GLOBAL_BYPASS_ATTRS_S  8'h08
`define TAP_OFF_STATUS  8'h0c
`define TAP_OFF_ABORTS  8'h10
// Control register bit positions
`define TAP_CTRL_EN_NS  0
`define TAP_CTRL_EN_S   1
`define TAP_CTRL_HTTU   2
`define TAP_CTRL_XNX    3
`define TAP_CTRL_RW_W   3
`define TAP_CTRL_RST    3'h0
`define TAP_GLOBAL_BYPASS_ATTRS_W      21
`define TAP_GLOBAL_BYPASS_ATTRS_RST    21'h0
`define TAP_STATUS_W    19
// Cacheability and shareability codes
`define TAP_CACHE_NC    2'h0
`define TAP_CACHE_WT    2'h1
`define TAP_CACHE_WB    2'h2
`define TAP_SH_NSH      2'h0
`define TAP_SH_OSH      2'h2
`define TAP_SH_ISH      2'h3
`define TAP_DEV_NONE    2'h3
// Override select: bit 1 set means take bit 0
`define TAP_CFG_SET     1
// Defaults for attributes the client leaves out
`define TAP_DEF_MEM     15'h0af3
`define TAP_DEF_INST    1'b0
`define TAP_DEF_PRIVILEGE_ATTR    1'b0
`define TAP_DEF_NS      1'b0
`define TAP_ATTR_INDEX_TABLE_EW     8
`endif

/* tap_pkg.sv */
`default_nettype none
package tap_pkg;
  typedef enum logic [1:0] {TAP_EL1, TAP_EL2, TAP_EL2_E2H, TAP_EL3} tap_regime_t;
  typedef struct packed {
    logic       dev;
    logic [1:0] dtype;
    logic [1:0] ic;
    logic [1:0] oc;
    logic [1:0] ra;   // [1] outer, [0] inner
    logic [1:0] wa;
    logic [1:0] tr;
    logic [1:0] sh;
  } tap_mem_t;
  typedef struct packed {
    tap_mem_t m;
    logic     rw;     // 1 = write
    logic     inst;
    logic     privilege_attr;
    logic     ns;
  } tap_attrs_t;
  typedef struct packed {
    logic mt, sh, al, inst, privilege_attr, ns;
  } tap_sup_t;
  typedef struct packed {
    logic       mt_en;
    logic       mt_dev;
    logic [1:0] mt_dt;
    logic [1:0] mt_ic;
    logic [1:0] mt_oc;
    logic       sh_en;
    logic [1:0] sh;
    logic       al_en;
    logic       ra, wa, tr;
    logic [1:0] privilege_attr_cfg;
    logic [1:0] inst_cfg;
    logic [1:0] ns_cfg;
  } tap_ovr_t;
  typedef struct packed {
    tap_attrs_t a;
    tap_sup_t   sup;
    logic       secure;   // stream_security_id says secure
    logic       spec;
  } tap_txn_t;
  typedef struct packed {
    logic     s1_en, s2_en, s2_sec_en, fwb;
    logic     s2_nsipa_walk_cfg, s2_nsipa_output_cfg, s2_sipa_walk_cfg, s2_sipa_output_cfg;
    tap_ovr_t ovr;
  } tap_ste_t;
  typedef struct packed {
    logic        fault;
    tap_regime_t regime;
    logic [63:0] attr_index_table;
    logic [2:0]  attr_index_field;
    logic [1:0]  sh;
    logic [1:0]  ap;      // access_perm_field [2:1]
    logic        pxn, uxn, af, dbm;
    logic        ns, tbl_ns, ttb;
    logic [1:0]  walk_nonsecure_cfg;
  } tap_s1_t;
  typedef struct packed {
    logic       fault;
    logic [3:0] s2_memory_attr_field;
    logic [1:0] sh;
    logic [1:0] s2ap;     // [1] write, [0] read
    logic [1:0] xn;
    logic       af, dbm;
  } tap_s2_t;
endpackage : tap_pkg
`default_nettype wire

/* tap_sink_model.sv */
`default_nettype none
module tap_sink_model
  import tap_pkg::*;
(
  input  wire logic       clk_i,    // Clock
  input  wire logic       nrst_i,   // Async reset, active low
  input  wire logic       vld_i,    // Output valid from block
  input  wire tap_attrs_t attrs_i,  // Attributes from block
  output logic [15:0]     cnt_o,    // Transactions accepted
  output tap_attrs_t      last_o    // Last accepted attributes
);
  timeunit 1ns;
  timeprecision 1ps;
  // Interconnect never stalls, so every valid beat is taken
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_o  <= '0;
      last_o <= '0;
    end else if (vld_i) begin
      cnt_o  <= cnt_o + 16'h0001;
      last_o <= attrs_i;
    end
  end
endmodule : tap_sink_model
`default_nettype wire

/* test_tap_attr_pipe.sv */
`default_nettype none
`include "tap_regs.svh"
module test_tap_attr_pipe
  import tap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [7:0]  addr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic        in_vld = 1'b0;
  tap_txn_t    txn = '0, tv;
  tap_ste_t    ste = '0, sv;
  tap_s1_t     s1 = '0, av;
  tap_s2_t     s2 = '0, bv;
  tap_ovr_t    ov;
  tap_attrs_t  out, last, ex;
  logic        out_vld, abort, evt, fs2, upd_af, upd_d, wns;
  logic [15:0] sink_cnt;
  int          miscompares = 0;
  int          tests_run = 0;
  int          sent = 0;
  always #10 clk_i = ~clk_i;
  tap_attr_pipe u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata),
    .we_i(we), .re_i(re), .rdata_o(rdata), .in_vld_i(in_vld), .txn_i(txn), .ste_i(ste),
    .s1_i(s1), .s2_i(s2), .out_vld_o(out_vld), .out_o(out), .abort_o(abort),
    .event_o(evt), .fault_s2_o(fs2), .upd_af_o(upd_af), .upd_dirty_o(upd_d),
    .s2_walk_ns_o(wns));
  tap_sink_model u_sink (.clk_i(clk_i), .nrst_i(nrst_i), .vld_i(out_vld), .attrs_i(out),
    .cnt_o(sink_cnt), .last_o(last));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic results();
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    we <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk_i);
    we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    re <= 1'b1; addr <= a;
    @(posedge clk_i);
    re <= 1'b0;
    #1 rv = rdata;
  endtask : rd
  // One transaction; flags stand only in the cycle after the request
  task automatic send(input logic ab, input logic ev);
    @(posedge clk_i);
    in_vld <= 1'b1; txn <= tv; ste <= sv; s1 <= av; s2 <= bv;
    @(posedge clk_i);
    in_vld <= 1'b0;
    sent++;
    #1;
    chk("out_vld", out_vld, 32'h1);
    chk("abort", abort, 32'(ab));
    chk("event", evt, 32'(ev));
  endtask : send
  task automatic test_regs();
    rd(`TAP_OFF_CTRL);
    chk("ctrl reset", rv, 32'h8);
    rd(8'h14);
    chk("unmapped", rv, 32'h0);
    rd(`TAP_OFF_GLOBAL_BYPASS_ATTRS_NS);
    chk("bypass reset", rv, 32'h0);
    wr(`TAP_OFF_CTRL, 32'h7);
    rd(`TAP_OFF_CTRL);
    chk("ctrl rw", rv, 32'hf);
    wr(`TAP_OFF_CTRL, 32'h0);
  endtask : test_regs
  task automatic test_bypass();
    tv = '0; sv = '0; av = '0; bv = '0;
    tv.a.m = 15'h4000;
    tv.a.rw = 1'b1;
    send(1'b0, 1'b0);
    ex = {15'(`TAP_DEF_MEM), 1'b1, 1'b0, 1'b0, 1'b1};
    chk("bypass ns out", out, ex);
    rd(`TAP_OFF_STATUS);
    chk("status", rv, {13'h0, ex});
    ov = '0; ov.mt_en = 1'b1; ov.mt_dev = 1'b1; ov.privilege_attr_cfg = 2'b11;
    wr(`TAP_OFF_GLOBAL_BYPASS_ATTRS_S, 32'(ov));
    tv.secure = 1'b1;
    send(1'b0, 1'b0);
    chk("bypass privilege_attr", out.privilege_attr, 32'h1);
    chk("bypass dev", out.m.dev, 32'h1);
    chk("dev sh", out.m.sh, `TAP_SH_OSH);
    chk("secure ns", out.ns, 32'h0);
    ov.mt_dev = 1'b0; ov.mt_ic = `TAP_CACHE_NC; ov.mt_oc = `TAP_CACHE_NC;
    wr(`TAP_OFF_GLOBAL_BYPASS_ATTRS_S, 32'(ov));
    send(1'b0, 1'b0);
    chk("nc sh", out.m.sh, `TAP_SH_OSH);
    chk("nc hints", {out.m.ra, out.m.wa, out.m.tr}, 32'h0);
  endtask : test_bypass
  task automatic test_stage1();
    wr(`TAP_OFF_CTRL, 32'h3);
    tv = '0; tv.secure = 1'b1; sv = '0; sv.s1_en = 1'b1;
    av = '0; av.ap = 2'b01; av.af = 1'b1;
    for (int i = 0; i < 16; i++) begin
      av.ns = i[0]; av.tbl_ns = i[1]; av.ttb = i[2]; av.walk_nonsecure_cfg = {i[3], 1'b0};
      send(1'b0, 1'b0);
      chk("s1 ns", out.ns, 32'(i[0] | i[1] | (i[2] & i[3])));
    end
    sv.ovr.privilege_attr_cfg = 2'b11;
    send(1'b0, 1'b0);
    chk("s1 privilege_attr", out.privilege_attr, 32'h1);
    sv.ovr.privilege_attr_cfg = 2'b00; av.ap = 2'b00;
    for (int r = 0; r < 4; r++) begin
      av.regime = tap_regime_t'(r);
      send(r == 0 || r == 2, r == 0 || r == 2);
    end
  endtask : test_stage1
  task automatic test_stage2();
    tv = '0; tv.secure = 1'b1; tv.sup.ns = 1'b1;
    sv = '0; sv.s2_en = 1'b1; sv.s2_sec_en = 1'b1;
    av = '0; bv = '0; bv.s2ap = 2'b11; bv.af = 1'b1; bv.s2_memory_attr_field = 4'hf;
    for (int i = 0; i < 32; i++) begin
      {sv.s2_sipa_output_cfg, sv.s2_sipa_walk_cfg, sv.s2_nsipa_output_cfg, sv.s2_nsipa_walk_cfg} = i[3:0];
      tv.a.ns = i[4];
      send(1'b0, 1'b0);
      chk("s2 walk", wns, 32'(i[4] ? i[0] : i[2]));
      chk("s2 ns", out.ns, 32'(i[4] ? |i[3:0] : i[2] | i[3]));
    end
    tv.secure = 1'b0; tv.a.ns = 1'b0;
    send(1'b0, 1'b0);
    chk("ns stream", out.ns, 32'h1);
    chk("ns walk", wns, 32'h1);
  endtask : test_stage2
  task automatic test_faults();
    tv = '0; sv = '0; sv.s1_en = 1'b1; bv = '0;
    av = '0; av.ap = 2'b01; av.fault = 1'b1;
    tv.spec = 1'b1;
    send(1'b1, 1'b0);
    tv.spec = 1'b0;
    send(1'b1, 1'b1);
    av.fault = 1'b0;
    wr(`TAP_OFF_CTRL, 32'h7);
    send(1'b0, 1'b0);
    chk("upd af", upd_af, 32'h1);
    wr(`TAP_OFF_CTRL, 32'h3);
    send(1'b1, 1'b1);
    rd(`TAP_OFF_ABORTS);
    chk("abort count", rv, 32'h5);
  endtask : test_faults
  // Memory type, shareability and hint paths through both stages
  task automatic test_combine();
    tv = '0; tv.sup.al = 1'b1; tv.sup.sh = 1'b1; tv.a.m.ra = 2'b01; tv.a.m.wa = 2'b11;
    sv = '0; sv.s1_en = 1'b1;
    av = '0; av.ap = 2'b01; av.af = 1'b1; av.sh = `TAP_SH_ISH; av.attr_index_field = 3'h1;
    av.attr_index_table = 64'h0000_0000_0044_ff00;
    bv = '0; bv.s2ap = 2'b11; bv.af = 1'b1; bv.sh = `TAP_SH_OSH; bv.s2_memory_attr_field = 4'ha;
    send(1'b0, 1'b0);
    chk("s1 mem", {out.m.dev, out.m[11:0]}, 32'h0a73);
    tv.sup.mt = 1'b1; tv.a.m.dev = 1'b1;
    send(1'b0, 1'b0);
    chk("s1 dev in", {out.m.dev, out.m[11:0]}, 32'h0af3);
    tv.sup.mt = 1'b0; sv.s2_en = 1'b1;
    send(1'b0, 1'b0);
    chk("s1 s2 mem", {out.m.dev, out.m[11:0]}, 32'h0572);
    av.attr_index_field = 3'h2; sv.fwb = 1'b1; bv.s2_memory_attr_field = 4'h7;
    send(1'b0, 1'b0);
    chk("fwb mem", {out.m.dev, out.m[11:0]}, 32'h0a02);
    sv = '0; sv.s2_en = 1'b1; sv.ovr.mt_en = 1'b1; sv.ovr.mt_ic = `TAP_CACHE_WT;
    sv.ovr.mt_oc = `TAP_CACHE_WT; sv.ovr.sh_en = 1'b1; sv.ovr.sh = `TAP_SH_ISH;
    bv.sh = `TAP_SH_NSH; bv.s2_memory_attr_field = 4'hf;
    send(1'b0, 1'b0);
    chk("s2 only mem", {out.m.dev, out.m[11:0]}, 32'h0573);
    tv.sup.inst = 1'b1; tv.a.inst = 1'b1; bv.xn = 2'h1;
    send(1'b0, 1'b0);
    chk("s2 fault none", fs2, 32'h0);
    tv.sup.privilege_attr = 1'b1; tv.a.privilege_attr = 1'b1;
    send(1'b1, 1'b1);
    chk("s2 fault", fs2, 32'h1);
    wr(`TAP_OFF_CTRL, 32'h7);
    tv = '0; tv.a.rw = 1'b1; sv = '0; sv.s1_en = 1'b1;
    av = '0; av.ap = 2'b11; av.af = 1'b1; av.dbm = 1'b1;
    send(1'b0, 1'b0);
    chk("upd dirty", upd_d, 32'h1);
    wr(`TAP_OFF_CTRL, 32'h3);
  endtask : test_combine
  initial begin
    #200000;
    miscompares++;
    results();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    test_regs();
    test_bypass();
    test_stage1();
    test_stage2();
    test_faults();
    test_combine();
    @(posedge clk_i);
    chk("sink count", sink_cnt, 32'(sent));
    results();
  end
endmodule : test_tap_attr_pipe
`default_nettype wire
